// ===== logic/seq_pkg.sv
/*
 * Shared constants, state codes and carrier structs for the two-wire bus sequencer.
 * Assumes one clock (sys_clk, 125 MHz) and a synchronous active-high reset everywhere.
 */
// Summary of operation
// - Master role only, never acts as slave.
// - Master starts, clocks and ends each transfer.
// - START/RESTART: SDA falls while SCL high.
// - STOP: SDA rises while SCL high.
// - RESTART keeps bus busy, same master.
// - SDA changes only while SCL is low.
// - Address plus direction after every start.
// - Receiving side drives the acknowledge bit.
// - Read: ack all bytes, nack the last.
// - Whole bytes, each with one ack clock.
// - Lines only pulled low or released.
// - Idle bus: both lines released.
// - Entry into empty queue starts a transfer.
// - Queue runs empty: finish byte, then STOP.
// - No room for read data: hold SCL low.
// - Combined reads and writes, 7/10-bit addressing.
// - Address format fixed within one transaction.
// - Restart enabled: direction change uses RESTART.
// - Empty queue at completion: STOP, later START.
// - 7-bit: address bits 7:1, direction bit 0.
// - 10-bit: marker, high address, then low byte.
// - Missing acknowledge from slave: abort with STOP.
// - Lost arbitration: release SDA for byte rest.
package seq_pkg;

    typedef enum logic [8:0] {
        ST_IDLE     = 9'h001,
        ST_START_SU = 9'h002,
        ST_START_HD = 9'h004,
        ST_LOW      = 9'h008,
        ST_HIGH     = 9'h010,
        ST_RS       = 9'h020,
        ST_STOP_LO  = 9'h040,
        ST_STOP_SU  = 9'h080,
        ST_STOP_BF  = 9'h100
    } bus_state_e;

    typedef enum logic [2:0] {
        PH_ADDR1 = 3'h1,
        PH_ADDR2 = 3'h2,
        PH_DATA  = 3'h4
    } byte_phase_e;

    typedef struct packed {
        logic rd;
        logic [7:0] data;
    } tx_entry_s;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } rx_word_s;

    localparam logic [4:0] TEN_BIT_MARK = 5'h1E;
    localparam logic [3:0] ACK_BIT_IDX = 4'h8;
    localparam logic [3:0] BIT_IDX_RST = 4'h0;
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam int CNT_W_DEFAULT = 16;

endpackage : seq_pkg

// ===== logic/phase_timer.sv
/*
 * Down-counter that times one SCL phase in sys_clk cycles.
 * Assumes start is a single-cycle pulse and load is at least one.
 */
`timescale 1ns/1ps
`default_nettype none
module phase_timer #(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [CNT_W-1:0] load,
    output logic done
);
    import seq_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic run_q;

    initial begin
        if (CNT_W < 2) begin
            $error("phase_timer needs CNT_W of at least 2");
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_q <= load;
                run_q <= 1'b1;
            end else if (run_q) begin
                if (cnt_q <= CNT_W'(1)) begin
                    run_q <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - CNT_W'(1);
                end
            end
        end
    end
endmodule // phase_timer
`default_nettype wire

// ===== logic/skid_buffer.sv
/*
 * Two-entry buffer with valid/ready on both sides; output data and valid are registered.
 * Assumes the source holds data while in_valid is high and in_ready low.
 */
`timescale 1ns/1ps
`default_nettype none
module skid_buffer #(
    parameter int W = 9
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    import seq_pkg::*;

    logic [W-1:0] spare_q;
    logic spare_v_q;
    logic spare_v_d;
    logic push;
    logic move;

    initial begin
        if (W < 1) begin
            $error("skid_buffer needs W of at least 1");
        end
    end

    assign push = in_valid && in_ready;
    assign move = !out_valid || out_ready;

    always_comb begin
        spare_v_d = spare_v_q;
        if (move) begin
            spare_v_d = spare_v_q && push;
        end else if (push) begin
            spare_v_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= '0;
            spare_q <= '0;
            spare_v_q <= 1'b0;
            in_ready <= 1'b0;
        end else begin
            spare_v_q <= spare_v_d;
            // Ready looks one cycle ahead so a full spare slot never drops a word
            in_ready <= !spare_v_d;
            if (move) begin
                if (spare_v_q) begin
                    out_data <= spare_q;
                    out_valid <= 1'b1;
                    if (push) begin
                        spare_q <= in_data;
                    end
                end else begin
                    out_valid <= push;
                    if (push) begin
                        out_data <= in_data;
                    end
                end
            end else if (push) begin
                spare_q <= in_data;
            end
        end
    end
endmodule // skid_buffer
`default_nettype wire

// ===== logic/bus_sequencer.sv
/*
 * Master-only two-wire bus sequencer: turns queued entries into START, address, data,
 * acknowledge, RESTART and STOP sequences, with read bytes leaving through a two-entry buffer.
 * Assumes external pull-ups on both lines, pin inputs synchronous to sys_clk, and a
 * transmit source that holds tx_valid/tx_entry stable until tx_ready is seen.
 */
`timescale 1ns/1ps
`default_nettype none
module bus_sequencer #(
    parameter int CNT_W = seq_pkg::CNT_W_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic restart_en,
    input wire logic addr_10bit,
    input wire logic [9:0] target_addr,
    input wire logic [CNT_W-1:0] scl_low_cnt,
    input wire logic [CNT_W-1:0] scl_high_cnt,
    input wire logic tx_valid,
    input wire seq_pkg::tx_entry_s tx_entry,
    output logic tx_ready,
    output logic rx_valid,
    input wire logic rx_ready,
    output seq_pkg::rx_word_s rx_word,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oen,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oen,
    output logic busy,
    output logic nack_seen,
    output logic arb_lost
);
    import seq_pkg::*;

    bus_state_e state_q;
    bus_state_e state_d;
    byte_phase_e phase_q;
    logic entry_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic cur_rd_q;
    logic ten_q;
    logic ten_rd_q;
    logic arb_q;
    logic armed_q;
    logic lo_done_q;
    logic pushed_q;
    logic [7:0] cur_data_q;
    logic tm_start;
    logic tm_done;
    logic [CNT_W-1:0] tm_load;
    logic rx_in_ready;
    logic rx_push;
    logic receiving;
    logic last_read;
    logic low_exit;
    logic byte_end;
    logic take_first;
    logic go_restart;
    logic go_stop;
    logic go_same;
    logic go_addr2;
    logic go_ten_rs;
    logic go_data;
    logic sda_rel;

    initial begin
        if (CNT_W < 2 || CNT_W > 32) begin
            $error("bus_sequencer needs CNT_W between 2 and 32");
        end
    end

    function automatic logic [7:0] first_byte(input logic ten, input logic [9:0] a, input logic rd);
        first_byte = ten ? {TEN_BIT_MARK, a[9:8], rd} : {a[6:0], rd};
    endfunction

    // Entries are pulled only in idle or at byte boundaries, so a one-cycle ready never doubles a pop
    assign take_first = (state_q == ST_IDLE) && enable && tx_valid;
    assign receiving = (phase_q == PH_DATA) && cur_rd_q;
    assign last_read = !(tx_valid && tx_entry.rd);
    assign rx_push = (state_q == ST_LOW) && receiving && (bit_q == ACK_BIT_IDX) && !pushed_q && rx_in_ready;
    assign low_exit = lo_done_q && (!(receiving && (bit_q == ACK_BIT_IDX)) || pushed_q);
    assign byte_end = (state_q == ST_HIGH) && tm_done && (bit_q == ACK_BIT_IDX);
    assign sda_rel = (phase_q == PH_DATA) ? cur_rd_q : 1'b0;

    // Decisions taken when the acknowledge clock of a byte ends
    always_comb begin
        go_restart = 1'b0;
        go_stop = 1'b0;
        go_same = 1'b0;
        go_addr2 = 1'b0;
        go_ten_rs = 1'b0;
        go_data = 1'b0;
        if (arb_q) begin
            go_stop = 1'b0;
        end else if (!receiving && sda_in) begin
            go_stop = 1'b1;
        end else if (phase_q == PH_ADDR1) begin
            go_addr2 = ten_q && !ten_rd_q;
            go_data = !(ten_q && !ten_rd_q);
        end else if (phase_q == PH_ADDR2) begin
            go_ten_rs = cur_rd_q;
            go_data = !cur_rd_q;
        end else if (!tx_valid || !enable) begin
            go_stop = 1'b1;
        end else if (tx_entry.rd == cur_rd_q) begin
            go_same = 1'b1;
        end else if (restart_en) begin
            go_restart = 1'b1;
        end else begin
            go_stop = 1'b1;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (take_first) begin
                state_d = ST_START_SU;
            end
            ST_START_SU: if (tm_done) begin
                state_d = ST_START_HD;
            end
            ST_START_HD: if (tm_done) begin
                state_d = ST_LOW;
            end
            ST_LOW: begin
                if (!enable) begin
                    state_d = ST_IDLE;
                end else if (low_exit) begin
                    state_d = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (tm_done) begin
                    if (bit_q != ACK_BIT_IDX) begin
                        state_d = ST_LOW;
                    end else if (arb_q) begin
                        state_d = ST_IDLE;
                    end else if (go_stop) begin
                        state_d = ST_STOP_LO;
                    end else if (go_restart || go_ten_rs) begin
                        state_d = ST_RS;
                    end else begin
                        state_d = ST_LOW;
                    end
                end
            end
            ST_RS: if (tm_done) begin
                state_d = ST_START_SU;
            end
            ST_STOP_LO: if (tm_done) begin
                state_d = ST_STOP_SU;
            end
            ST_STOP_SU: if (tm_done) begin
                state_d = ST_STOP_BF;
            end
            ST_STOP_BF: if (tm_done) begin
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            entry_q <= 1'b0;
        end else begin
            state_q <= state_d;
            entry_q <= (state_d != state_q);
        end
    end

    // Phase timing; the high phase waits for the line to read high so a stretching slave is honoured
    always_comb begin
        tm_load = scl_high_cnt;
        tm_start = entry_q && (state_q != ST_HIGH) && (state_q != ST_IDLE);
        if (state_q == ST_LOW || state_q == ST_RS || state_q == ST_STOP_LO) begin
            tm_load = scl_low_cnt;
        end
        if (state_q == ST_HIGH) begin
            tm_start = scl_in && !armed_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            armed_q <= 1'b0;
            lo_done_q <= 1'b0;
        end else begin
            armed_q <= (state_q == ST_HIGH) && (armed_q || scl_in) && (state_d == ST_HIGH);
            if (state_q != ST_LOW || entry_q) begin
                lo_done_q <= 1'b0;
            end else if (tm_done) begin
                lo_done_q <= 1'b1;
            end
        end
    end

    // Clock line: only ever pulled low or released
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scl_oen <= 1'b1;
            scl_out <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            case (state_d)
                ST_LOW, ST_RS, ST_STOP_LO: scl_oen <= 1'b0;
                default: scl_oen <= 1'b1;
            endcase
        end
    end

    // Data line moves one cycle after SCL has gone low, or on the start and stop edges
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sda_oen <= 1'b1;
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            case (state_q)
                ST_IDLE, ST_START_SU: sda_oen <= 1'b1;
                ST_START_HD: sda_oen <= 1'b0;
                ST_LOW: begin
                    if (!enable) begin
                        sda_oen <= 1'b1;
                    end else if (entry_q) begin
                        if (bit_q == ACK_BIT_IDX) begin
                            sda_oen <= receiving ? last_read : 1'b1;
                        end else begin
                            sda_oen <= arb_q || sda_rel || shift_q[7];
                        end
                    end
                end
                ST_RS: if (entry_q) begin
                    sda_oen <= 1'b1;
                end
                ST_STOP_LO: if (entry_q) begin
                    sda_oen <= 1'b0;
                end
                ST_STOP_BF: sda_oen <= 1'b1;
                default: sda_oen <= sda_oen;
            endcase
        end
    end

    // Byte sequencing, address building and sampling
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase_q <= PH_ADDR1;
            bit_q <= BIT_IDX_RST;
            shift_q <= SHIFT_RST;
            cur_rd_q <= 1'b0;
            ten_q <= 1'b0;
            ten_rd_q <= 1'b0;
            arb_q <= 1'b0;
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= 1'b0;
            if (take_first) begin
                tx_ready <= 1'b1;
                cur_rd_q <= tx_entry.rd;
                ten_q <= addr_10bit;
                ten_rd_q <= 1'b0;
                phase_q <= PH_ADDR1;
                bit_q <= BIT_IDX_RST;
                arb_q <= 1'b0;
                // A 10-bit read first goes out as a write so the low address byte can follow
                shift_q <= first_byte(addr_10bit, target_addr, tx_entry.rd && !addr_10bit);
            end else if (state_q == ST_HIGH && tm_done) begin
                if (bit_q != ACK_BIT_IDX) begin
                    bit_q <= bit_q + 4'h1;
                    if (receiving) begin
                        shift_q <= {shift_q[6:0], sda_in};
                    end else begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        if (sda_oen && !arb_q && !sda_in) begin
                            arb_q <= 1'b1;
                        end
                    end
                end else begin
                    bit_q <= BIT_IDX_RST;
                    if (go_addr2) begin
                        phase_q <= PH_ADDR2;
                        shift_q <= target_addr[7:0];
                    end else if (go_ten_rs) begin
                        ten_rd_q <= 1'b1;
                        phase_q <= PH_ADDR1;
                        shift_q <= first_byte(1'b1, target_addr, 1'b1);
                    end else if (go_data) begin
                        phase_q <= PH_DATA;
                        shift_q <= cur_data_q;
                    end else if (go_same || go_restart) begin
                        tx_ready <= 1'b1;
                        cur_rd_q <= tx_entry.rd;
                        if (go_same) begin
                            shift_q <= tx_entry.data;
                        end else begin
                            ten_rd_q <= 1'b0;
                            phase_q <= PH_ADDR1;
                            shift_q <= first_byte(ten_q, target_addr, tx_entry.rd && !ten_q);
                        end
                    end
                end
            end
        end
    end

    // Write data is parked here while the address bytes go out
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur_data_q <= SHIFT_RST;
        end else if (take_first || (byte_end && (go_same || go_restart))) begin
            cur_data_q <= tx_entry.data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || state_q != ST_LOW) begin
            pushed_q <= 1'b0;
        end else if (rx_push) begin
            pushed_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busy <= 1'b0;
            nack_seen <= 1'b0;
            arb_lost <= 1'b0;
        end else begin
            busy <= (state_d != ST_IDLE);
            nack_seen <= byte_end && !receiving && sda_in && !arb_q;
            arb_lost <= byte_end && arb_q;
        end
    end

    phase_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(tm_start),
        .load(tm_load),
        .done(tm_done)
    );

    skid_buffer #(
        .W($bits(rx_word_s))
    ) u_rx_buf (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(rx_push),
        .in_ready(rx_in_ready),
        .in_data({last_read, shift_q}),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_word)
    );
endmodule // bus_sequencer
`default_nettype wire

// ===== bench/bus_sequencer_props.sv
/* Concurrent checks on the sequencer's ports.
   Assumes external pull-ups so scl_in/sda_in show the wired-AND level. */
`timescale 1ns/1ps
`default_nettype none
module bus_sequencer_props
    import seq_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [CNT_W-1:0] scl_low_cnt,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire seq_pkg::rx_word_s rx_word,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oen,
    input wire logic sda_out,
    input wire logic sda_oen,
    input wire logic busy,
    input wire logic nack_seen,
    input wire logic arb_lost
);
    localparam int LIM = 60;
    logic [CNT_W-1:0] low_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Saturates so a long stall cannot wrap into a false short phase
    always_ff @(posedge sys_clk) begin
        if (rst || scl_oen) low_q <= '0;
        else if (low_q != '1) low_q <= low_q + 1'b1;
    end
    a_out_low_only: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("line driven high");
    a_idle_release: assert property (!busy && $past(!busy) |-> scl_oen)
        else $error("clock pulled while idle");
    a_start_busy: assert property ($fell(sda_oen) && scl_in |-> ##[0:2] busy)
        else $error("start without busy");
    a_stop_idle: assert property ($rose(sda_oen) && scl_in && $past(scl_in) && busy
        |-> scl_oen throughout (##[1:LIM] !busy))
        else $error("data rose in high phase without stop");
    a_tx_pulse: assert property (tx_ready |-> $past(tx_valid) ##1 !tx_ready)
        else $error("bad take pulse");
    a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
        else $error("read word lost");
    a_nack_stop: assert property (nack_seen |-> ##[0:LIM] ($rose(sda_oen) && scl_in))
        else $error("no stop after nack");
    a_low_phase: assert property ($rose(scl_oen) && busy |-> low_q >= scl_low_cnt)
        else $error("low phase short");
    a_arb_release: assert property (arb_lost |-> ##[0:2] (sda_oen && scl_oen))
        else $error("lines held after lost arbitration");
endmodule // bus_sequencer_props
bind bus_sequencer bus_sequencer_props #(.CNT_W(CNT_W)) u_props (.sys_clk(sys_clk), .rst(rst),
    .scl_low_cnt(scl_low_cnt), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_word(rx_word), .scl_in(scl_in), .scl_out(scl_out), .scl_oen(scl_oen),
    .sda_out(sda_out), .sda_oen(sda_oen), .busy(busy), .nack_seen(nack_seen), .arb_lost(arb_lost));
`default_nettype wire

// ===== bench/bus_slave_model.sv
/* Behavioural addressed slave: acks or refuses, returns rd_byte on reads.
   Assumes lines are oversampled by sys_clk; SCL is never stretched here. */
`timescale 1ns/1ps
`default_nettype none
module bus_slave_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic nack_all,
    input wire logic [7:0] rd_byte,
    output logic sda_oen,
    output logic got_stb,
    output logic [8:0] got
);
    logic scl_q, sda_q, first_q, rd_q, mack_q, tx_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    always_ff @(posedge sys_clk) begin
        scl_q <= scl;
        sda_q <= sda;
        got_stb <= 1'b0;
        if (rst || (scl && scl_q && sda != sda_q)) begin
            cnt_q <= 4'h0;
            first_q <= 1'b1;
            tx_q <= 1'b0;
            sda_oen <= 1'b1;
        end else if (scl && !scl_q) begin
            if (cnt_q < 4'h8) sh_q <= {sh_q[6:0], sda};
            if (cnt_q == 4'h8) mack_q <= !sda;
            cnt_q <= cnt_q + 4'h1;
        end else if (!scl && scl_q) begin
            if (cnt_q == 4'h8) begin
                if (first_q) rd_q <= sh_q[0];
                got_stb <= !tx_q;
                got <= {first_q, sh_q};
                // Refusal leaves SDA released so the master can stop
                sda_oen <= tx_q | nack_all;
            end else if (cnt_q == 4'h9) begin
                cnt_q <= 4'h0;
                first_q <= 1'b0;
                tx_q <= rd_q & mack_q;
                sda_oen <= !(rd_q & mack_q) | rd_byte[7];
            end else if (tx_q) sda_oen <= rd_byte[4'h7 - cnt_q];
        end
    end
endmodule // bus_slave_model
`default_nettype wire

// ===== bench/bus_sequencer_tb.sv
/* Self-checking bench for bus_sequencer against the slave model.
   Assumes the checker is bound in and counts of 2..4 cycles. */
`timescale 1ns/1ps
`default_nettype none
module bus_sequencer_tb;
    import seq_pkg::*;
    logic sys_clk = 0, rst = 1, enable = 0, restart_en = 0, addr_10bit = 0, tx_valid = 0;
    logic rx_ready = 0, nack_all = 0, arb_pull = 0, stall = 0, busy_q = 0;
    logic [9:0] target_addr = 10'h000;
    logic [15:0] lo = 16'h0003, hi = 16'h0003;
    logic [7:0] rd_byte = 8'h00;
    tx_entry_s tx_entry = '0;
    rx_word_s rx_word;
    logic tx_ready, rx_valid, scl_out, scl_oen, sda_out, sda_oen, busy, nack_seen, arb_lost, slv_oen, got_stb;
    logic [8:0] got;
    wire logic scl = scl_oen;
    wire logic sda = sda_oen & slv_oen & ~arb_pull;
    tx_entry_s q[$];
    logic [8:0] seen[$], exp[$], rxs[$], rxe[$];
    int num_errors = 0, comparisons = 0, stops = 0, nacks = 0, arbs = 0;
    bus_sequencer #(.CNT_W(16)) DUT (.sys_clk(sys_clk), .rst(rst), .enable(enable), .restart_en(restart_en),
        .addr_10bit(addr_10bit), .target_addr(target_addr), .scl_low_cnt(lo), .scl_high_cnt(hi),
        .tx_valid(tx_valid), .tx_entry(tx_entry), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_word(rx_word), .scl_in(scl), .scl_out(scl_out), .scl_oen(scl_oen),
        .sda_in(sda), .sda_out(sda_out), .sda_oen(sda_oen), .busy(busy), .nack_seen(nack_seen),
        .arb_lost(arb_lost));
    bus_slave_model slave (.sys_clk(sys_clk), .rst(rst), .scl(scl), .sda(sda), .nack_all(nack_all),
        .rd_byte(rd_byte), .sda_oen(slv_oen), .got_stb(got_stb), .got(got));
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (tx_ready && q.size() > 0) void'(q.pop_front());
        tx_valid <= q.size() > 0;
        if (q.size() > 0) tx_entry <= q[0];
        rx_ready <= !stall && $urandom_range(0, 3) != 0;
        if (got_stb) seen.push_back(got);
        if (rx_valid && rx_ready) rxs.push_back(rx_word);
        if (busy_q && !busy) stops++;
        busy_q <= busy;
        nacks += nack_seen;
        arbs += arb_lost;
    end
    task automatic finish_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [8:0] g, input logic [8:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tmo(input int n, input int lim);
        if (n >= lim) begin
            num_errors++;
            finish_test();
        end
    endtask
    task automatic cfg(input logic ten, input logic rs);
        @(posedge sys_clk);
        addr_10bit <= ten;
        restart_en <= rs;
        target_addr <= 10'($urandom);
        rd_byte <= 8'($urandom);
        lo <= 16'($urandom_range(2, 4));
        hi <= 16'($urandom_range(2, 4));
        @(posedge sys_clk);
    endtask
    // Queues one direction segment and the bus bytes it must produce
    task automatic seg(input logic rd, input int n);
        logic [7:0] b;
        if (addr_10bit) begin
            exp.push_back({1'b1, TEN_BIT_MARK, target_addr[9:8], 1'b0});
            exp.push_back({1'b0, target_addr[7:0]});
            if (rd) exp.push_back({1'b1, TEN_BIT_MARK, target_addr[9:8], 1'b1});
        end else exp.push_back({1'b1, target_addr[6:0], rd});
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            q.push_back({rd, b});
            if (!rd) exp.push_back({1'b0, b});
            else rxe.push_back({i == n - 1, rd_byte});
        end
    endtask
    task automatic run(input int nst, input int nn);
        int n, idle;
        n = 0;
        idle = 0;
        while ((q.size() > 0 || idle < 8) && n < 20000) begin
            @(posedge sys_clk);
            n++;
            idle = (busy === 1'b0) ? idle + 1 : 0;
        end
        tmo(n, 20000);
        check(9'(seen.size()), 9'(exp.size()));
        foreach (exp[i]) check(seen[i], exp[i]);
        check(9'(rxs.size()), 9'(rxe.size()));
        foreach (rxe[i]) check(rxs[i], rxe[i]);
        check(9'(stops), 9'(nst));
        check(9'(nacks), 9'(nn));
        exp.delete();
        rxe.delete();
        seen.delete();
        rxs.delete();
        stops = 0;
        nacks = 0;
    endtask
    initial begin
        int n;
        void'($urandom(13));
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        cfg(1'b0, 1'b0);
        seg(1'b0, 3);
        repeat (100) @(posedge sys_clk);
        check({8'h00, busy}, 9'h000);
        check({7'h00, scl, sda}, 9'h003);
        enable <= 1'b1;
        run(1, 0);
        for (int k = 0; k < 6; k++) begin
            cfg(1'b0, k[0]);
            seg(1'b0, 1 + $urandom_range(0, 2));
            seg(1'b1, 1 + $urandom_range(0, 1));
            run(k[0] ? 1 : 2, 0);
        end
        cfg(1'b0, 1'b0);
        stall <= 1'b1;
        seg(1'b1, 4);
        fork
            run(1, 0);
            begin
                repeat (800) @(posedge sys_clk);
                check({8'h00, scl}, 9'h000);
                stall <= 1'b0;
            end
        join
        cfg(1'b1, 1'b1);
        seg(1'b1, 2);
        run(1, 0);
        cfg(1'b1, 1'b0);
        seg(1'b0, 2);
        run(1, 0);
        cfg(1'b0, 1'b0);
        nack_all <= 1'b1;
        seg(1'b0, 1);
        void'(exp.pop_back());
        run(1, 1);
        // Second master forces the first address bit low
        target_addr <= 10'h3FF;
        @(posedge sys_clk);
        seg(1'b0, 1);
        n = 0;
        while (!(busy === 1'b1 && scl === 1'b0) && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        arb_pull <= 1'b1;
        while (arbs == 0 && n < 4000) begin
            @(posedge sys_clk);
            n++;
        end
        tmo(n, 4000);
        arb_pull <= 1'b0;
        repeat (50) @(posedge sys_clk);
        check(9'(arbs), 9'h001);
        check({7'h00, scl, sda}, 9'h003);
        exp.delete();
        seen.delete();
        stops = 0;
        nacks = 0;
        run(0, 0);
        finish_test();
    end
endmodule // bus_sequencer_tb
`default_nettype wire
